// File: rtl/fault_limit_pkg.sv
// package for the fault limit command bank: command codes, defaults, states
// assumes a 40 MHz system clock and 16-bit command words
package fault_limit_pkg;

  localparam int REG_COUNT = 12;
  localparam int IDX_W     = 4;
  localparam int DATA_W    = 16;
  localparam int CODE_W    = 8;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_IOUT_WARN   = 8'h4a;
  localparam logic [7:0] CMD_OT_FAULT    = 8'h4f;
  localparam logic [7:0] CMD_OT_ACTION   = 8'h50;
  localparam logic [7:0] CMD_OT_WARN     = 8'h51;
  localparam logic [7:0] CMD_VIN_OV      = 8'h55;
  localparam logic [7:0] CMD_VIN_ACTION  = 8'h56;
  localparam logic [7:0] CMD_VIN_UV_WARN = 8'h58;
  localparam logic [7:0] CMD_IIN_WARN    = 8'h5d;
  localparam logic [7:0] CMD_PG_ON       = 8'h5e;
  localparam logic [7:0] CMD_PG_OFF      = 8'h5f;
  localparam logic [7:0] CMD_TON_WAIT    = 8'h60;
  localparam logic [7:0] CMD_TON_RAMP    = 8'h61;

  // ==========================================================================
  // storage indices
  localparam logic [3:0] IDX_IOUT_WARN   = 4'h0;
  localparam logic [3:0] IDX_OT_FAULT    = 4'h1;
  localparam logic [3:0] IDX_OT_ACTION   = 4'h2;
  localparam logic [3:0] IDX_OT_WARN     = 4'h3;
  localparam logic [3:0] IDX_VIN_OV      = 4'h4;
  localparam logic [3:0] IDX_VIN_ACTION  = 4'h5;
  localparam logic [3:0] IDX_VIN_UV_WARN = 4'h6;
  localparam logic [3:0] IDX_IIN_WARN    = 4'h7;
  localparam logic [3:0] IDX_PG_ON       = 4'h8;
  localparam logic [3:0] IDX_PG_OFF      = 4'h9;
  localparam logic [3:0] IDX_TON_WAIT    = 4'ha;
  localparam logic [3:0] IDX_TON_RAMP    = 4'hb;

  // ==========================================================================
  // non-volatile defaults; the output current warning default is build-specific
  localparam logic [15:0] DEF_IOUT_WARN   = 16'hf868;
  localparam logic [15:0] DEF_OT_FAULT    = 16'h007d;
  localparam logic [15:0] DEF_OT_ACTION   = 16'h00f9;
  localparam logic [15:0] DEF_OT_WARN     = 16'h0069;
  localparam logic [15:0] DEF_VIN_OV      = 16'hf81e;
  localparam logic [15:0] DEF_VIN_ACTION  = 16'h00b8;
  localparam logic [15:0] DEF_VIN_UV_WARN = 16'hf812;
  localparam logic [15:0] DEF_IIN_WARN    = 16'hf80a;
  localparam logic [15:0] DEF_PG_ON       = 16'h0114;
  localparam logic [15:0] DEF_PG_OFF      = 16'h0105;
  localparam logic [15:0] DEF_TON_WAIT    = 16'h0000;
  localparam logic [15:0] DEF_TON_RAMP    = 16'h0005;

  localparam logic [7:0]  OT_RETRY_ACTION  = 8'hf9;
  localparam logic [7:0]  VIN_LATCH_ACTION = 8'hb8;
  localparam logic [7:0]  BYTE_MASK        = 8'hff;
  localparam logic [15:0] ZERO_WORD        = 16'h0000;

  typedef enum logic [3:0] {
    ST_OFF      = 4'b0001,
    ST_RUN      = 4'b0010,
    ST_OT_RETRY = 4'b0100,
    ST_LATCHED  = 4'b1000
  } supply_state_e;

  // maps a command code to {hit, index}
  function automatic logic [4:0] decode_cmd(input logic [7:0] code);
    logic [4:0] r;
    r = 5'h00;
    case (code)
      CMD_IOUT_WARN:   r = {1'b1, IDX_IOUT_WARN};
      CMD_OT_FAULT:    r = {1'b1, IDX_OT_FAULT};
      CMD_OT_ACTION:   r = {1'b1, IDX_OT_ACTION};
      CMD_OT_WARN:     r = {1'b1, IDX_OT_WARN};
      CMD_VIN_OV:      r = {1'b1, IDX_VIN_OV};
      CMD_VIN_ACTION:  r = {1'b1, IDX_VIN_ACTION};
      CMD_VIN_UV_WARN: r = {1'b1, IDX_VIN_UV_WARN};
      CMD_IIN_WARN:    r = {1'b1, IDX_IIN_WARN};
      CMD_PG_ON:       r = {1'b1, IDX_PG_ON};
      CMD_PG_OFF:      r = {1'b1, IDX_PG_OFF};
      CMD_TON_WAIT:    r = {1'b1, IDX_TON_WAIT};
      CMD_TON_RAMP:    r = {1'b1, IDX_TON_RAMP};
      default:         r = 5'h00;
    endcase
    return r;
  endfunction

  // byte-wide commands keep only their low byte
  function automatic logic is_byte_cmd(input logic [3:0] idx);
    return (idx == IDX_OT_ACTION) || (idx == IDX_VIN_ACTION);
  endfunction

endpackage

// File: rtl/pin_sync.sv
// two-flop synchroniser for a bundle of pin levels
// assumes the pins are asynchronous to sys_clk_in
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             sys_clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_stage1 = pins_in;
    next_sync   = stage1;
    if (!resetn_in) begin
      next_stage1 = '0;
      next_sync   = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    stage1   <= next_stage1;
    sync_out <= next_sync;
  end
endmodule

// File: rtl/limit_store.sv
// storage for the limit, response and timing words, loaded with defaults
// assumes index and hit come from the command decoder on the same clock
`timescale 1ns/1ps
module limit_store
  import fault_limit_pkg::*;
(
  input  wire logic          sys_clk_in,
  input  wire logic          resetn_in,
  input  wire logic          wr_en_in,
  input  wire logic          rd_en_in,
  input  wire logic          hit_in,
  input  wire logic [3:0]    idx_in,
  input  wire logic [15:0]   wr_data_in,
  output logic      [15:0]   rd_data_out,
  output logic      [7:0]    ot_action_out,
  output logic      [7:0]    vin_action_out
);
  logic [15:0] mem [REG_COUNT];
  logic [15:0] next_mem [REG_COUNT];
  logic [15:0] next_rd;
  logic [15:0] defaults [REG_COUNT];

  always_comb begin
    defaults[IDX_IOUT_WARN]   = DEF_IOUT_WARN;
    defaults[IDX_OT_FAULT]    = DEF_OT_FAULT;
    defaults[IDX_OT_ACTION]   = DEF_OT_ACTION;
    defaults[IDX_OT_WARN]     = DEF_OT_WARN;
    defaults[IDX_VIN_OV]      = DEF_VIN_OV;
    defaults[IDX_VIN_ACTION]  = DEF_VIN_ACTION;
    defaults[IDX_VIN_UV_WARN] = DEF_VIN_UV_WARN;
    defaults[IDX_IIN_WARN]    = DEF_IIN_WARN;
    defaults[IDX_PG_ON]       = DEF_PG_ON;
    defaults[IDX_PG_OFF]      = DEF_PG_OFF;
    defaults[IDX_TON_WAIT]    = DEF_TON_WAIT;
    defaults[IDX_TON_RAMP]    = DEF_TON_RAMP;
  end

  always_comb begin
    next_mem = mem;
    next_rd  = rd_data_out;
    if (wr_en_in && hit_in) begin
      next_mem[idx_in] = is_byte_cmd(idx_in) ?
                         {8'h00, wr_data_in[7:0]} : wr_data_in;
    end
    if (rd_en_in) begin
      next_rd = hit_in ? mem[idx_in] : ZERO_WORD;
    end
    if (!resetn_in) begin
      next_mem = defaults;
      next_rd  = ZERO_WORD;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    mem         <= next_mem;
    rd_data_out <= next_rd;
  end

  assign ot_action_out  = mem[IDX_OT_ACTION][7:0];
  assign vin_action_out = mem[IDX_VIN_ACTION][7:0];
endmodule

// File: rtl/fault_limit_bank.sv
// Contract
// - default over-temperature response holds output off
// - default over-temperature response retries without limit
// - commanded off ends the over-temperature retry
// - bias loss or other fault ends retry
// - default input overvoltage response never restarts
// - default input overvoltage response keeps output off until cleared
//
// fault limit command bank with fault response sequencing
// assumes command strobes come from the bus engine on sys_clk_in and
// fault, enable and bias levels arrive asynchronously from pins/comparators
`timescale 1ns/1ps
module fault_limit_bank
  import fault_limit_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic        wr_strobe_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic        rd_strobe_in,
  input  wire logic        operation_on_in,
  input  wire logic        clear_faults_in,
  input  wire logic        enable_pin_in,
  input  wire logic        bias_ok_in,
  input  wire logic        ot_fault_in,
  input  wire logic        vin_ov_fault_in,
  input  wire logic        other_fault_in,
  output logic      [15:0] rd_data_out,
  output logic             rd_valid_out,
  output logic             cmd_unmapped_out,
  output logic             output_enable_out,
  output logic             retry_active_out,
  output logic             fault_latched_out
);
  // ==========================================================================
  // pin synchronisation
  logic [4:0] pins_sync;
  logic       en_s;
  logic       bias_s;
  logic       ot_s;
  logic       vin_s;
  logic       other_s;

  pin_sync #(.WIDTH(5)) u_sync (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .pins_in    ({enable_pin_in, bias_ok_in, ot_fault_in,
                  vin_ov_fault_in, other_fault_in}),
    .sync_out   (pins_sync)
  );
  assign {en_s, bias_s, ot_s, vin_s, other_s} = pins_sync;

  // ==========================================================================
  // command decode and storage
  logic [4:0] dec;
  logic [7:0] ot_action;
  logic [7:0] vin_action;

  assign dec = decode_cmd(cmd_code_in);

  limit_store u_store (
    .sys_clk_in     (sys_clk_in),
    .resetn_in      (resetn_in),
    .wr_en_in       (wr_strobe_in),
    .rd_en_in       (rd_strobe_in),
    .hit_in         (dec[4]),
    .idx_in         (dec[3:0]),
    .wr_data_in     (wr_data_in),
    .rd_data_out    (rd_data_out),
    .ot_action_out  (ot_action),
    .vin_action_out (vin_action)
  );

  logic next_rd_valid;
  logic next_unmapped;

  always_comb begin
    next_rd_valid = rd_strobe_in;
    next_unmapped = (rd_strobe_in || wr_strobe_in) && !dec[4];
    if (!resetn_in) begin
      next_rd_valid = 1'b0;
      next_unmapped = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    rd_valid_out     <= next_rd_valid;
    cmd_unmapped_out <= next_unmapped;
  end

  // ==========================================================================
  // fault response sequencing
  supply_state_e state;
  supply_state_e next_state;
  logic          next_oe;
  logic          next_retry;
  logic          next_latched;
  logic          commanded_on;
  logic          ot_retry_mode;
  logic          vin_latch_mode;

  assign commanded_on   = en_s && operation_on_in;
  assign ot_retry_mode  = (ot_action & BYTE_MASK) == OT_RETRY_ACTION;
  assign vin_latch_mode = (vin_action & BYTE_MASK) == VIN_LATCH_ACTION;

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (commanded_on && bias_s && !ot_s && !vin_s && !other_s) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!commanded_on || !bias_s) begin
          next_state = ST_OFF;
        end else if (other_s) begin
          next_state = ST_LATCHED;
        end else if (vin_s) begin
          // default response: no restart, held until cleared
          next_state = vin_latch_mode ? ST_LATCHED : ST_OFF;
        end else if (ot_s) begin
          next_state = ot_retry_mode ? ST_OT_RETRY : ST_LATCHED;
        end
      end
      ST_OT_RETRY: begin
        if (!commanded_on) begin
          next_state = ST_OFF;
        end else if (!bias_s) begin
          next_state = ST_OFF;
        end else if (other_s || vin_s) begin
          next_state = ST_LATCHED;
        end else if (!ot_s) begin
          next_state = ST_RUN;
        end
      end
      ST_LATCHED: begin
        if (clear_faults_in && !vin_s && !ot_s && !other_s) begin
          next_state = ST_OFF;
        end
      end
      default: next_state = ST_OFF;
    endcase
    next_oe      = (next_state == ST_RUN);
    next_retry   = (next_state == ST_OT_RETRY);
    next_latched = (next_state == ST_LATCHED);
    if (!resetn_in) begin
      next_state   = ST_OFF;
      next_oe      = 1'b0;
      next_retry   = 1'b0;
      next_latched = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    state             <= next_state;
    output_enable_out <= next_oe;
    retry_active_out  <= next_retry;
    fault_latched_out <= next_latched;
  end
endmodule

// File: sim/fault_limit_bank_monitor.sv
// checker for the fault limit bank port behaviour
// assumes the 3-cycle pin-to-output latency of the bank
`timescale 1ns/1ps
module fault_limit_bank_monitor (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic rd_strobe_in,
  input wire logic operation_on_in,
  input wire logic clear_faults_in,
  input wire logic enable_pin_in,
  input wire logic bias_ok_in,
  input wire logic ot_fault_in,
  input wire logic vin_ov_fault_in,
  input wire logic other_fault_in,
  input wire logic rd_valid_out,
  input wire logic output_enable_out,
  input wire logic retry_active_out,
  input wire logic fault_latched_out
);
  // ==========================================================================
  // assertions
  logic run_ok;
  assign run_ok = enable_pin_in & operation_on_in & bias_ok_in
                & ~ot_fault_in & ~vin_ov_fault_in & ~other_fault_in;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  chk_read_answer: assert property (
    rd_strobe_in |=> rd_valid_out) else $error("read gave no answer");
  chk_valid_cause: assert property (
    !rd_strobe_in |=> !rd_valid_out) else $error("read answer unasked");
  chk_ot_off: assert property (
    ot_fault_in [*4] |-> !output_enable_out) else $error("on in overtemp");
  // pins must be good for two cycles before the retry sample as well, so
  // that no older fault still in the synchroniser can latch the output off
  chk_ot_resume: assert property (
    run_ok [*2] ##1 (retry_active_out && run_ok) ##1 run_ok [*3] |->
    ##[0:3] output_enable_out) else $error("no restart after overtemp");
  chk_cmd_off: assert property (
    retry_active_out && !operation_on_in |-> ##[1:4] !retry_active_out)
    else $error("retry kept after off");
  chk_bias_stop: assert property (
    retry_active_out && !bias_ok_in ##1 !bias_ok_in [*2] |-> ##[0:2]
    !retry_active_out) else $error("retry kept without bias");
  chk_vin_off: assert property (
    vin_ov_fault_in [*4] |-> !output_enable_out) else $error("on in vin ov");
  chk_latch_holds: assert property (
    fault_latched_out && !clear_faults_in |=> fault_latched_out)
    else $error("latch left without clear");
  chk_latch_dark: assert property (
    fault_latched_out |=> !output_enable_out) else $error("on from latch");
endmodule

bind fault_limit_bank fault_limit_bank_monitor mon (.sys_clk_in,
  .resetn_in, .rd_strobe_in, .operation_on_in, .clear_faults_in,
  .enable_pin_in, .bias_ok_in, .ot_fault_in, .vin_ov_fault_in,
  .other_fault_in, .rd_valid_out, .output_enable_out, .retry_active_out,
  .fault_latched_out);

// File: sim/pmbus_host_model.sv
// host side of the command bank: issues word writes and reads
// assumes one strobe per command, answer registered on the edge that takes the strobe
`timescale 1ns/1ps
module pmbus_host_model (
  input  wire logic        sys_clk_in,
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in,
  input  wire logic        unmapped_in,
  output logic      [7:0]  cmd_code_out,
  output logic             wr_strobe_out,
  output logic      [15:0] wr_data_out,
  output logic             rd_strobe_out
);
  initial begin
    cmd_code_out = 8'h00;
    wr_strobe_out = 1'b0;
    wr_data_out = 16'h0000;
    rd_strobe_out = 1'b0;
  end
  task automatic write_word(input logic [7:0] code, input logic [15:0] data);
    @(posedge sys_clk_in);
    #2;
    cmd_code_out = code;
    wr_data_out = data;
    wr_strobe_out = 1'b1;
    @(posedge sys_clk_in);
    #2;
    wr_strobe_out = 1'b0;
    // released data lines do not keep the last word
    wr_data_out = ~data;
  endtask
  task automatic read_word(input logic [7:0] code, output logic [15:0] data,
                           output logic miss);
    @(posedge sys_clk_in);
    #2;
    cmd_code_out = code;
    rd_strobe_out = 1'b1;
    @(posedge sys_clk_in);
    #2;
    data = (rd_valid_in === 1'b1) ? rd_data_in : 16'hxxxx;
    miss = unmapped_in;
    rd_strobe_out = 1'b0;
  endtask
endmodule

// File: sim/fault_limit_bank_bench.sv
// self-checking bench for the fault limit command bank
// assumes the pmbus host model and the bound port checker
`timescale 1ns/1ps
module fault_limit_bank_bench
  import fault_limit_pkg::*;
;
  logic        sys_clk_in, resetn_in, wr, rd, op, clr, en, bias, ot, vin;
  logic        oth, rv, um, oe, rt, lt, m;
  logic [7:0]  cmd;
  logic [15:0] wd, rdat, d;
  int          bad_count, n_tests, cycles;
  logic [7:0]  codes [12] = '{CMD_IOUT_WARN, CMD_OT_FAULT, CMD_OT_ACTION,
    CMD_OT_WARN, CMD_VIN_OV, CMD_VIN_ACTION, CMD_VIN_UV_WARN, CMD_IIN_WARN,
    CMD_PG_ON, CMD_PG_OFF, CMD_TON_WAIT, CMD_TON_RAMP};
  logic [15:0] defs [12] = '{DEF_IOUT_WARN, 16'h007d, 16'h00f9, 16'h0069,
    16'hf81e, 16'h00b8, 16'hf812, 16'hf80a, 16'h0114, 16'h0105, 16'h0000,
    16'h0005};
  pmbus_host_model host (.sys_clk_in, .rd_data_in(rdat), .rd_valid_in(rv),
    .unmapped_in(um), .cmd_code_out(cmd), .wr_strobe_out(wr),
    .wr_data_out(wd), .rd_strobe_out(rd));
  fault_limit_bank uut (.sys_clk_in, .resetn_in, .cmd_code_in(cmd),
    .wr_strobe_in(wr), .wr_data_in(wd), .rd_strobe_in(rd),
    .operation_on_in(op), .clear_faults_in(clr), .enable_pin_in(en),
    .bias_ok_in(bias), .ot_fault_in(ot), .vin_ov_fault_in(vin),
    .other_fault_in(oth), .rd_data_out(rdat), .rd_valid_out(rv),
    .cmd_unmapped_out(um), .output_enable_out(oe), .retry_active_out(rt),
    .fault_latched_out(lt));
  // ==========================================================================
  // helpers
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (6) @(posedge sys_clk_in);
    #2;
  endtask
  // state as {output on, retrying, latched}
  task automatic st(input logic [2:0] exp);
    check("state", {13'h0000, oe, rt, lt}, {13'h0000, exp});
  endtask
  task automatic pulse_clear();
    clr = 1'b1;
    @(posedge sys_clk_in);
    #2;
    clr = 1'b0;
    settle();
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================================
  // tests
  initial begin
    {op, clr, en, bias, ot, vin, oth} = 7'h00;
    resetn_in = 1'b0;
    repeat (5) @(posedge sys_clk_in);
    #2;
    resetn_in = 1'b1;
    for (int i = 0; i < 12; i++) begin
      host.read_word(codes[i], d, m);
      check("default", d, defs[i]);
    end
    $display("test defaults done");
    host.write_word(CMD_OT_FAULT, 16'h0080);
    host.read_word(CMD_OT_FAULT, d, m);
    check("ot limit", d, 16'h0080);
    check("hit", {15'h0000, m}, 16'h0000);
    host.write_word(CMD_OT_ACTION, 16'ha5c3);
    host.read_word(CMD_OT_ACTION, d, m);
    check("byte word", d, 16'h00c3);
    host.write_word(8'h52, 16'h1234);
    host.read_word(8'h52, d, m);
    check("unmapped", d, 16'h0000);
    check("miss", {15'h0000, m}, 16'h0001);
    host.write_word(CMD_OT_ACTION, 16'h00f9);
    $display("test access done");
    {en, op, bias} = 3'b111;
    settle();
    st(3'b100);
    ot = 1'b1;
    settle();
    settle();
    st(3'b010);
    ot = 1'b0;
    settle();
    st(3'b100);
    ot = 1'b1;
    settle();
    op = 1'b0;
    settle();
    st(3'b000);
    {op, ot} = 2'b10;
    settle();
    ot = 1'b1;
    settle();
    bias = 1'b0;
    settle();
    st(3'b000);
    {bias, ot} = 2'b10;
    settle();
    ot = 1'b1;
    settle();
    oth = 1'b1;
    settle();
    st(3'b001);
    {oth, ot} = 2'b00;
    settle();
    st(3'b001);
    pulse_clear();
    st(3'b100);
    $display("test overtemp done");
    vin = 1'b1;
    settle();
    st(3'b001);
    vin = 1'b0;
    settle();
    settle();
    st(3'b001);
    pulse_clear();
    st(3'b100);
    $display("test input overvoltage done");
    // non-default responses: overtemp latches, input overvoltage restarts
    host.write_word(CMD_OT_ACTION, 16'h00c0);
    ot = 1'b1;
    settle();
    st(3'b001);
    ot = 1'b0;
    settle();
    pulse_clear();
    st(3'b100);
    host.write_word(CMD_VIN_ACTION, 16'h00c0);
    vin = 1'b1;
    settle();
    st(3'b000);
    vin = 1'b0;
    settle();
    st(3'b100);
    $display("test other responses done");
    conclude();
  end
endmodule
